// File: dv/interrupt_vector_dispatch_tb.sv
`timescale 1ns/1ns
`default_nettype none
module interrupt_vector_dispatch_tb;
  localparam logic [19:0] BASE = 20'h0c000;
  logic clk, rst, undefined_opcode_instr, ovf, ovf_f, breakpoint_instr, sw, ev, me0, me1, wdt, osc, vm1;
  logic vm2;
  logic ss, ab, ifl, reti, reti_u, uw, uwd, redir, slow;
  logic [5:0] num;
  logic [19:0] ea;
  logic [31:0] per;
  wire rd, ack, busy, pack, sack, disp, uflag, push, pushu, mack;
  wire [7:0] md;
  wire [19:0] ma, pc;
  wire [4:0] pnum;
  wire [3:0] ssrc, src;
  int n_tests = 0;
  int n_mismatch = 0;
  always #5 clk = ~clk;
  ivd_dispatch #(.AW(20)) u_dut (.ref_clk_in(clk), .rst_in(rst),
    .ce_in(1'b1), .undefined_opcode_instr_in(undefined_opcode_instr),
    .overflow_trap_instr_in(ovf), .overflow_flag_in(ovf_f),
    .breakpoint_instr_in(breakpoint_instr), .swint_instr_in(sw), .swint_num_in(num),
    .exec_valid_in(ev), .exec_addr_in(ea), .match_enable_0_in(me0),
    .match_enable_1_in(me1), .match_address_0_in(20'h01234),
    .match_address_1_in(20'h04320), .wdt_req_in(wdt),
    .osc_stop_req_in(osc), .vmon1_req_in(vm1), .vmon2_req_in(vm2),
    .single_step_req_in(ss), .addr_break_req_in(ab), .periph_req_in(per),
    .i_flag_in(ifl), .relocatable_table_base_in(BASE), .reti_in(reti),
    .reti_u_in(reti_u), .u_write_in(uw), .u_wdata_in(uwd),
    .mem_ack_in(ack), .mem_data_in(md), .mem_rd_out(rd),
    .mem_addr_out(ma), .busy_out(busy), .periph_ack_out(pack),
    .periph_ack_num_out(pnum), .special_ack_out(sack),
    .special_ack_src_out(ssrc), .amatch_ack_out(mack), .dispatch_out(disp),
    .pc_out(pc), .source_out(src), .u_flag_out(uflag),
    .stack_push_out(push), .stack_u_out(pushu), .id_byte_valid_out(),
    .id_byte_addr_out(), .id_byte_out());
  ivd_mem_model u_mem (.ref_clk_in(clk), .rd_in(rd), .addr_in(ma),
    .redir_in(redir), .slow_in(slow), .ack_out(ack), .data_out(md));
  function automatic logic [19:0] epc(input logic [19:0] a);
    logic [7:0] b0, b1, b2;
    b0 = a[7:0] ^ 8'h5a;
    b1 = (a[7:0] + 8'h01) ^ 8'h5a;
    b2 = (a[7:0] + 8'h02) ^ 8'h5a;
    return {b2[3:0], b1, b0};
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string name, input logic [19:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // request was set at the previous falling edge; drop it once taken
  task automatic run(input logic [3:0] s, input logic [19:0] a);
    int k;
    @(negedge clk);
    {undefined_opcode_instr, ovf, breakpoint_instr, sw, ev, wdt, osc, vm1, vm2, ss, ab} = '0;
    per = 32'h0;
    k = 0;
    while (disp !== 1'b1 && k < 60) begin
      @(negedge clk);
      k++;
    end
    if (k == 60) begin
      n_mismatch++;
      final_report();
    end
    chk("pc", pc, epc(a));
    chk("source", {16'h0, src}, {16'h0, s});
  endtask
  initial begin
    {clk, undefined_opcode_instr, ovf, ovf_f, breakpoint_instr, sw, ev, me0, me1, wdt, osc, vm1, vm2} = '0;
    {ss, ab, ifl, reti, reti_u, uw, uwd, redir, slow} = '0;
    rst = 1'b1;
    num = 6'h00;
    ea = 20'h00000;
    per = 32'h0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    run(4'h7, 20'h0fffc);
    for (int k = 0; k < 7; k++) begin
      case (k)
        0: undefined_opcode_instr = 1'b1;
        1: begin
          ovf = 1'b1;
          ovf_f = 1'b1;
        end
        2: breakpoint_instr = 1'b1;
        3: begin
          me0 = 1'b1;
          ev = 1'b1;
          ea = 20'h01234;
        end
        4: ss = 1'b1;
        5: wdt = 1'b1;
        default: ab = 1'b1;
      endcase
      #1 chk("amatch", {19'h0, mack}, {19'h0, k == 3});
      run(k[3:0], 20'h0ffdc + 20'(k * 4));
    end
    // second comparator alone, first one enabled on another address
    me1 = 1'b1;
    ev = 1'b1;
    ea = 20'h04320;
    #1 chk("amatch1", {19'h0, mack}, 20'h1);
    run(4'h3, 20'h0ffe8);
    $display("test fixed vectors done");
    ovf = 1'b1;
    ovf_f = 1'b0;
    per = 32'h0000002f;
    repeat (3) @(negedge clk);
    chk("busy", {19'h0, busy}, 20'h0);
    ovf = 1'b0;
    ifl = 1'b1;
    #1 chk("periph", {14'h0, pack, pnum}, 20'h00023);
    run(4'h9, BASE + 20'h0000c);
    $display("test masking done");
    slow = 1'b1;
    ifl = 1'b0;
    for (int i = 0; i < 4; i++) begin
      {wdt, osc, vm1, vm2} = 4'h8 >> i;
      #1 chk("special", {15'h0, sack, ssrc}, {15'h0, 1'b1, 4'h8 >> i});
      run(4'h5, 20'h0fff0);
    end
    slow = 1'b0;
    redir = 1'b1;
    breakpoint_instr = 1'b1;
    run(4'h2, BASE);
    redir = 1'b0;
    $display("test special and breakpoint done");
    uw = 1'b1;
    uwd = 1'b1;
    @(negedge clk);
    uw = 1'b0;
    sw = 1'b1;
    num = 6'h05;
    @(negedge clk);
    chk("push", {18'h0, push, pushu}, 20'h3);
    chk("uflag", {19'h0, uflag}, 20'h0);
    run(4'h8, BASE + 20'h00014);
    reti = 1'b1;
    reti_u = 1'b1;
    @(negedge clk);
    reti = 1'b0;
    chk("uflag", {19'h0, uflag}, 20'h1);
    for (int j = 0; j < 3; j++) begin
      sw = 1'b1;
      num = (j == 0) ? 6'h28 : (j == 1) ? 6'h3f : 6'h1f;
      @(negedge clk);
      if (j < 2) chk("keep", {18'h0, push, uflag}, 20'h1);
      run(4'h8, BASE + {12'h0, num, 2'h0});
    end
    $display("test numbered interrupts done");
    final_report();
  end
endmodule
`default_nettype wire

// File: dv/ivd_dispatch_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module ivd_dispatch_monitor #(
  parameter AW = 20
) (
  input wire logic ref_clk_in, // clock
  input wire logic rst_in, // reset
  input wire logic ce_in, // enable
  input wire logic undefined_opcode_instr_in, // undef
  input wire logic overflow_trap_instr_in, // ovf trap
  input wire logic overflow_flag_in, // ovf flag
  input wire logic breakpoint_instr_in, // brk
  input wire logic swint_instr_in, // swint
  input wire logic [5:0] swint_num_in, // number
  input wire logic exec_valid_in, // exec
  input wire logic wdt_req_in, // watchdog
  input wire logic i_flag_in, // global enable
  input wire logic mem_ack_in, // byte ack
  input wire logic [7:0] mem_data_in, // byte data
  input wire logic mem_rd_out, // byte req
  input wire logic [AW-1:0] mem_addr_out, // byte addr
  input wire logic busy_out, // busy
  input wire logic periph_ack_out, // periph ack
  input wire logic special_ack_out, // special ack
  input wire logic [3:0] special_ack_src_out, // special src
  input wire logic dispatch_out, // dispatch
  input wire logic u_flag_out, // stack flag
  input wire logic stack_push_out, // push
  input wire logic stack_u_out, // pushed flag
  input wire logic id_byte_valid_out, // id valid
  input wire logic [AW-1:0] id_byte_addr_out, // id addr
  input wire logic [7:0] id_byte_out // id byte
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  wire take = ce_in && !busy_out;
  wire hi_ovf = overflow_trap_instr_in && overflow_flag_in;
  // swint outranks every source below brk, so these three are enough
  wire sw_wins = take && swint_instr_in && !undefined_opcode_instr_in &&
    !hi_ovf && !breakpoint_instr_in;
  property p_und_vec;
    take && undefined_opcode_instr_in |=>
      mem_rd_out && mem_addr_out == 20'h0ffdc;
  endproperty
  a_und_vec: assert property (p_und_vec)
    else $error("undefined opcode vector address wrong");
  property p_ovf_vec;
    take && hi_ovf && !undefined_opcode_instr_in |=>
      mem_addr_out == 20'h0ffe0;
  endproperty
  a_ovf_vec: assert property (p_ovf_vec)
    else $error("overflow trap vector address wrong");
  property p_brk_id;
    take && breakpoint_instr_in && !undefined_opcode_instr_in && !hi_ovf
      |=> mem_rd_out && mem_addr_out == 20'h0ffe7;
  endproperty
  a_brk_id: assert property (p_brk_id)
    else $error("breakpoint did not read redirect byte");
  property p_spec_nomask;
    take && wdt_req_in && !undefined_opcode_instr_in && !hi_ovf &&
      !breakpoint_instr_in && !swint_instr_in && !exec_valid_in
      |-> special_ack_out && special_ack_src_out[3];
  endproperty
  a_spec_nomask: assert property (p_spec_nomask)
    else $error("watchdog request not taken");
  property p_periph_mask;
    periph_ack_out |-> i_flag_in && take;
  endproperty
  a_periph_mask: assert property (p_periph_mask)
    else $error("peripheral taken while masked");
  property p_disp_ack;
    // last ack is seen by the fetcher, then by the dispatcher
    dispatch_out |-> $past(mem_ack_in, 2) && !busy_out;
  endproperty
  a_disp_ack: assert property (p_disp_ack)
    else $error("dispatch not after last vector byte");
  property p_push_clr;
    sw_wins && !swint_num_in[5] |=> stack_push_out &&
      stack_u_out == $past(u_flag_out) && !u_flag_out;
  endproperty
  a_push_clr: assert property (p_push_clr)
    else $error("low swint did not save and clear stack flag");
  property p_hi_keep;
    sw_wins && swint_num_in[5] |=>
      !stack_push_out && u_flag_out == $past(u_flag_out);
  endproperty
  a_hi_keep: assert property (p_hi_keep)
    else $error("high swint changed stack flag");
  property p_id_byte;
    id_byte_valid_out |-> id_byte_addr_out[1:0] == 2'h3 &&
      id_byte_addr_out >= 20'h0ffdc && id_byte_addr_out <= 20'h0ffff;
  endproperty
  a_id_byte: assert property (p_id_byte)
    else $error("id byte outside fixed vector high lanes");
  property p_id_data;
    id_byte_valid_out |-> id_byte_out == $past(mem_data_in) &&
      id_byte_addr_out == $past(mem_addr_out);
  endproperty
  a_id_data: assert property (p_id_data)
    else $error("id byte differs from fetched vector byte");
  property p_rd_hold;
    mem_rd_out && !mem_ack_in |=> mem_rd_out && $stable(mem_addr_out);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("vector byte request dropped before ack");
endmodule
bind ivd_dispatch ivd_dispatch_monitor #(.AW(AW)) u_mon (.ref_clk_in,
  .rst_in, .ce_in, .undefined_opcode_instr_in, .overflow_trap_instr_in,
  .overflow_flag_in, .breakpoint_instr_in, .swint_instr_in, .swint_num_in,
  .exec_valid_in, .wdt_req_in, .i_flag_in, .mem_ack_in, .mem_rd_out,
  .mem_addr_out, .busy_out, .periph_ack_out, .special_ack_out,
  .special_ack_src_out, .dispatch_out, .u_flag_out, .stack_push_out,
  .stack_u_out, .id_byte_valid_out, .id_byte_addr_out, .mem_data_in,
  .id_byte_out);
`default_nettype wire

// File: dv/ivd_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module ivd_mem_model (
  input wire logic ref_clk_in, // clock
  input wire logic rd_in, // byte request
  input wire logic [19:0] addr_in, // byte address
  input wire logic redir_in, // id byte reads ffh
  input wire logic slow_in, // add wait states
  output logic ack_out, // byte valid
  output logic [7:0] data_out // byte
);
  logic [1:0] wait_reg;
  initial begin
    ack_out = 1'b0;
    data_out = 8'h00;
    wait_reg = 2'h0;
  end
  always @(posedge ref_clk_in) begin
    ack_out <= 1'b0;
    // an idle bus never repeats the last byte
    data_out <= ~data_out;
    if (rd_in && !ack_out) begin
      if (slow_in && wait_reg != 2'h2) begin
        wait_reg <= wait_reg + 2'h1;
      end else begin
        wait_reg <= 2'h0;
        ack_out <= 1'b1;
        if (redir_in && addr_in == 20'h0ffe7) begin
          data_out <= 8'hff;
        end else begin
          data_out <= addr_in[7:0] ^ 8'h5a;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: inc/ivd_defs.vh
`ifndef IVD_DEFS_VH
`define IVD_DEFS_VH
// fixed vector slots, 4 bytes each, low byte first
`define IVD_VEC_UND 20'h0ffdc
`define IVD_VEC_OVERFLOW_TRAP_INSTR 20'h0ffe0
`define IVD_VEC_BRK 20'h0ffe4
`define IVD_VEC_AMATCH 20'h0ffe8
`define IVD_VEC_SSTEP 20'h0ffec
`define IVD_VEC_SPECIAL 20'h0fff0
`define IVD_VEC_ABREAK 20'h0fff4
`define IVD_VEC_RSVD 20'h0fff8
`define IVD_VEC_RESET 20'h0fffc
`define IVD_FIX_LO 20'h0ffdc
`define IVD_FIX_HI 20'h0ffff
// top byte of the breakpoint slot decides redirection
`define IVD_BRK_ID_BYTE 20'h0ffe7
`define IVD_BRK_REDIR 8'hff
`define IVD_VEC_HI_LANE 2'h3
`define IVD_VEC_LAST 2'h3
// software numbers
`define IVD_SW_MAX 6'h3f
`define IVD_SW_U_LIMIT 6'h1f
`define IVD_PER_FIRST 5'h03
`define IVD_PER_MASK 32'hfffffff8
// source codes
`define IVD_SRC_UND 4'h0
`define IVD_SRC_OVERFLOW_TRAP_INSTR 4'h1
`define IVD_SRC_BRK 4'h2
`define IVD_SRC_AMATCH 4'h3
`define IVD_SRC_SSTEP 4'h4
`define IVD_SRC_SPECIAL 4'h5
`define IVD_SRC_ABREAK 4'h6
`define IVD_SRC_RESET 4'h7
`define IVD_SRC_SWINT 4'h8
`define IVD_SRC_PERIPH 4'h9
`endif

// File: src/ivd_dispatch.v
// What this block does
// - breakpoint instruction raises software breakpoint interrupt
// - numbered software interrupt accepts numbers 0..63
// - numbers 3..31 share peripheral vectors
// - numbers 0..31 push stack flag, select interrupt stack
// - return restores stack flag from stack copy, except from numbers 32..63
// - numbers 32..63 leave stack flag unchanged
// - special interrupts ignore global enable
// - watchdog, oscillator stop, voltage monitors are special
// - two enabled address comparators trigger before execution
// - peripheral requests are maskable
// - each vector is four bytes
// - acknowledge loads program counter from source vector
// - fixed table spans 0FFDCh to 0FFFFh
// - fixed slots in documented order, 4-byte steps
// - breakpoint redirects when 0FFE7h holds FFh
// - fixed vector high bytes feed id check
// - overflow trap only when overflow flag set
// - global enable gates maskable requests only
// - relocatable table spans 256 bytes from base
`timescale 1ns/1ns
`default_nettype none
`include "ivd_defs.vh"
module ivd_dispatch #(
  parameter AW = 20,
  parameter NEST = 8
) (
  input wire ref_clk_in, // cpu clock
  input wire rst_in, // sync reset, high
  input wire ce_in, // clock enable
  input wire undefined_opcode_instr_in, // undefined opcode executed
  input wire overflow_trap_instr_in, // overflow trap executed
  input wire overflow_flag_in, // overflow flag value
  input wire breakpoint_instr_in, // breakpoint executed
  input wire swint_instr_in, // numbered software interrupt
  input wire [5:0] swint_num_in, // its operand
  input wire exec_valid_in, // instruction about to execute
  input wire [AW-1:0] exec_addr_in, // its address
  input wire match_enable_0_in, // comparator 0 enable
  input wire match_enable_1_in, // comparator 1 enable
  input wire [AW-1:0] match_address_0_in, // comparator 0 address
  input wire [AW-1:0] match_address_1_in, // comparator 1 address
  input wire wdt_req_in, // watchdog request
  input wire osc_stop_req_in, // oscillation stop request
  input wire vmon1_req_in, // voltage monitor 1 request
  input wire vmon2_req_in, // voltage monitor 2 request
  input wire single_step_req_in, // tool single step
  input wire addr_break_req_in, // tool address break
  input wire [31:0] periph_req_in, // peripheral requests by number
  input wire i_flag_in, // global interrupt enable
  input wire [AW-1:0] relocatable_table_base_in, // table base
  input wire reti_in, // return from handler
  input wire reti_u_in, // stack flag popped from stack
  input wire u_write_in, // core writes stack flag
  input wire u_wdata_in, // value written
  input wire mem_ack_in, // vector byte returned
  input wire [7:0] mem_data_in, // vector byte
  output wire mem_rd_out, // vector byte request
  output wire [AW-1:0] mem_addr_out, // vector byte address
  output wire busy_out, // dispatch in progress
  output wire periph_ack_out, // peripheral request taken
  output wire [4:0] periph_ack_num_out, // its number
  output wire special_ack_out, // special request taken
  output wire [3:0] special_ack_src_out, // wdt,osc,vm1,vm2 taken
  output wire amatch_ack_out, // address match taken
  output wire dispatch_out, // load pc pulse
  output wire [AW-1:0] pc_out, // handler start address
  output wire [3:0] source_out, // source code of dispatch
  output wire u_flag_out, // stack select flag
  output wire stack_push_out, // push stack flag pulse
  output wire stack_u_out, // value to push
  output wire id_byte_valid_out, // id check byte pulse
  output wire [AW-1:0] id_byte_addr_out, // its address
  output wire [7:0] id_byte_out // its value
);
  localparam [1:0] ST_BOOT = 2'h0;
  localparam [1:0] ST_IDLE = 2'h1;
  localparam [1:0] ST_BRKCHK = 2'h2;
  localparam [1:0] ST_FETCH = 2'h3;
  localparam PW = $clog2(NEST + 1);

  reg [1:0] state_reg, state_next;
  reg [3:0] src_reg, src_next;
  reg [5:0] num_reg, num_next;
  reg u_flag_reg;
  reg push_reg;
  reg push_u_reg;
  reg disp_reg;
  reg [AW-1:0] pc_reg;
  reg [3:0] dsrc_reg;
  reg [NEST-1:0] saved_reg;
  reg [PW-1:0] depth_reg;
  reg idv_reg;
  reg [AW-1:0] ida_reg;
  reg [7:0] idb_reg;
  reg f_start, f_single;
  reg [AW-1:0] f_addr;
  reg take;
  reg save_u;
  wire f_busy, f_done;
  wire [31:0] f_vec;

  // relocatable entry N lies within the 256-byte table
  function [AW-1:0] reloc_addr;
    input [AW-1:0] base;
    input [5:0] n;
    begin
      reloc_addr = base + {{(AW-8){1'b0}}, n, 2'b00};
    end
  endfunction

  // fixed slots, numbered sources go relocatable
  function [AW-1:0] vec_addr;
    input [3:0] src;
    input [5:0] n;
    input [AW-1:0] base;
    begin
      case (src)
        `IVD_SRC_UND: vec_addr = `IVD_VEC_UND;
        `IVD_SRC_OVERFLOW_TRAP_INSTR: vec_addr = `IVD_VEC_OVERFLOW_TRAP_INSTR;
        `IVD_SRC_BRK: vec_addr = `IVD_VEC_BRK;
        `IVD_SRC_AMATCH: vec_addr = `IVD_VEC_AMATCH;
        `IVD_SRC_SSTEP: vec_addr = `IVD_VEC_SSTEP;
        `IVD_SRC_SPECIAL: vec_addr = `IVD_VEC_SPECIAL;
        `IVD_SRC_ABREAK: vec_addr = `IVD_VEC_ABREAK;
        `IVD_SRC_RESET: vec_addr = `IVD_VEC_RESET;
        default: vec_addr = reloc_addr(base, n);
      endcase
    end
  endfunction

  // lowest pending number wins; level arbitration lives elsewhere
  function [4:0] lowest;
    input [31:0] req;
    integer i;
    begin
      lowest = 5'h0;
      for (i = 31; i >= 0; i = i - 1) begin
        if (req[i]) begin
          lowest = i[4:0];
        end
      end
    end
  endfunction

  wire am0 = match_enable_0_in && (exec_addr_in == match_address_0_in);
  wire am1 = match_enable_1_in && (exec_addr_in == match_address_1_in);
  wire amatch = exec_valid_in && (am0 || am1);
  wire [3:0] spc = {wdt_req_in, osc_stop_req_in,
    vmon1_req_in, vmon2_req_in};
  // special sources bypass the enable flag entirely
  wire special = |spc;
  wire [31:0] per_live = periph_req_in & `IVD_PER_MASK;
  wire per_ok = i_flag_in && (|per_live);
  wire [4:0] per_num = lowest(per_live);
  wire ovf_trap = overflow_trap_instr_in && overflow_flag_in;
  wire idle = (state_reg == ST_IDLE);

  always @* begin
    state_next = state_reg;
    src_next = src_reg;
    num_next = num_reg;
    f_start = 1'b0;
    f_single = 1'b0;
    f_addr = {AW{1'b0}};
    take = 1'b0;
    save_u = 1'b1;
    case (state_reg)
      ST_BOOT: begin
        src_next = `IVD_SRC_RESET;
        f_start = 1'b1;
        f_addr = `IVD_VEC_RESET;
        state_next = ST_FETCH;
      end
      ST_IDLE: begin
        take = 1'b1;
        num_next = 6'h0;
        if (undefined_opcode_instr_in) begin
          src_next = `IVD_SRC_UND;
        end else if (ovf_trap) begin
          src_next = `IVD_SRC_OVERFLOW_TRAP_INSTR;
        end else if (breakpoint_instr_in) begin
          src_next = `IVD_SRC_BRK;
        end else if (swint_instr_in) begin
          src_next = `IVD_SRC_SWINT;
          num_next = swint_num_in;
          save_u = (swint_num_in <= `IVD_SW_U_LIMIT);
        end else if (amatch) begin
          src_next = `IVD_SRC_AMATCH;
        end else if (special) begin
          src_next = `IVD_SRC_SPECIAL;
        end else if (single_step_req_in) begin
          src_next = `IVD_SRC_SSTEP;
        end else if (addr_break_req_in) begin
          src_next = `IVD_SRC_ABREAK;
        end else if (per_ok) begin
          src_next = `IVD_SRC_PERIPH;
          num_next = {1'b0, per_num};
        end else begin
          take = 1'b0;
        end
        if (take) begin
          f_start = 1'b1;
          if (src_next == `IVD_SRC_BRK) begin
            f_single = 1'b1;
            f_addr = `IVD_BRK_ID_BYTE;
            state_next = ST_BRKCHK;
          end else begin
            f_addr = vec_addr(src_next, num_next,
              relocatable_table_base_in);
            state_next = ST_FETCH;
          end
        end
      end
      ST_BRKCHK: begin
        if (f_done) begin
          f_start = 1'b1;
          state_next = ST_FETCH;
          if (f_vec[7:0] == `IVD_BRK_REDIR) begin
            f_addr = reloc_addr(relocatable_table_base_in, 6'h0);
          end else begin
            f_addr = `IVD_VEC_BRK;
          end
        end
      end
      ST_FETCH: begin
        if (f_done) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_BOOT;
      end
    endcase
  end

  wire took = ce_in && take;
  assign busy_out = !idle;
  assign periph_ack_out = took && (src_next == `IVD_SRC_PERIPH);
  assign periph_ack_num_out = per_num;
  assign special_ack_out = took && (src_next == `IVD_SRC_SPECIAL);
  assign special_ack_src_out = special_ack_out ? spc : 4'h0;
  assign amatch_ack_out = took && (src_next == `IVD_SRC_AMATCH);

  ivd_vec_fetch #(
    .AW(AW)
  ) u_fetch (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .start_in(f_start),
    .single_in(f_single),
    .addr_in(f_addr),
    .mem_ack_in(mem_ack_in),
    .mem_data_in(mem_data_in),
    .mem_rd_out(mem_rd_out),
    .mem_addr_out(mem_addr_out),
    .busy_out(f_busy),
    .done_out(f_done),
    .vector_out(f_vec)
  );

  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_reg <= ST_BOOT;
      src_reg <= `IVD_SRC_RESET;
      num_reg <= 6'h0;
      disp_reg <= 1'b0;
      pc_reg <= {AW{1'b0}};
      dsrc_reg <= `IVD_SRC_RESET;
    end else if (ce_in) begin
      state_reg <= state_next;
      src_reg <= src_next;
      num_reg <= num_next;
      disp_reg <= 1'b0;
      if (state_reg == ST_FETCH && f_done) begin
        disp_reg <= 1'b1;
        pc_reg <= f_vec[AW-1:0];
        dsrc_reg <= src_reg;
      end
    end
  end

  // one saved-flag marker per nesting level tells a return whether
  // the stack copy of the flag is to be restored
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      u_flag_reg <= 1'b0;
      push_reg <= 1'b0;
      push_u_reg <= 1'b0;
      saved_reg <= {NEST{1'b0}};
      depth_reg <= {PW{1'b0}};
    end else if (ce_in) begin
      push_reg <= 1'b0;
      if (took) begin
        if (save_u) begin
          push_reg <= 1'b1;
          push_u_reg <= u_flag_reg;
          u_flag_reg <= 1'b0;
        end
        saved_reg <= {saved_reg[NEST-2:0], save_u};
        depth_reg <= depth_reg + {{(PW-1){1'b0}}, (depth_reg < NEST)};
      end else if (reti_in && depth_reg != {PW{1'b0}}) begin
        if (saved_reg[0]) begin
          u_flag_reg <= reti_u_in;
        end
        saved_reg <= {1'b0, saved_reg[NEST-1:1]};
        depth_reg <= depth_reg - {{(PW-1){1'b0}}, 1'b1};
      end else if (u_write_in) begin
        u_flag_reg <= u_wdata_in;
      end
    end
  end

  // high byte of each fixed slot is copied out for the id check
  wire in_fix = (mem_addr_out >= `IVD_FIX_LO) &&
    (mem_addr_out <= `IVD_FIX_HI);
  wire hi_lane = (mem_addr_out[1:0] == `IVD_VEC_HI_LANE);

  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      idv_reg <= 1'b0;
      ida_reg <= {AW{1'b0}};
      idb_reg <= 8'h0;
    end else if (ce_in) begin
      idv_reg <= 1'b0;
      if (f_busy && mem_ack_in && in_fix && hi_lane) begin
        idv_reg <= 1'b1;
        ida_reg <= mem_addr_out;
        idb_reg <= mem_data_in;
      end
    end
  end

  assign dispatch_out = disp_reg;
  assign pc_out = pc_reg;
  assign source_out = dsrc_reg;
  assign u_flag_out = u_flag_reg;
  assign stack_push_out = push_reg;
  assign stack_u_out = push_u_reg;
  assign id_byte_valid_out = idv_reg;
  assign id_byte_addr_out = ida_reg;
  assign id_byte_out = idb_reg;
endmodule
`default_nettype wire

// File: src/ivd_vec_fetch.v
`timescale 1ns/1ns
`default_nettype none
`include "ivd_defs.vh"
// reads one byte or one 4-byte vector, low address first
module ivd_vec_fetch #(
  parameter AW = 20
) (
  input wire ref_clk_in, // cpu clock
  input wire rst_in, // sync reset, high
  input wire ce_in, // clock enable
  input wire start_in, // begin a read
  input wire single_in, // read only one byte
  input wire [AW-1:0] addr_in, // first byte address
  input wire mem_ack_in, // byte returned
  input wire [7:0] mem_data_in, // returned byte
  output wire mem_rd_out, // byte read request
  output wire [AW-1:0] mem_addr_out, // byte address
  output wire busy_out, // read in progress
  output wire done_out, // read finished pulse
  output wire [31:0] vector_out // assembled bytes
);
  reg busy_reg;
  reg single_reg;
  reg done_reg;
  reg [1:0] cnt_reg;
  reg [AW-1:0] addr_reg;
  reg [31:0] vec_reg;
  wire last = single_reg | (cnt_reg == `IVD_VEC_LAST);

  assign mem_rd_out = busy_reg;
  assign mem_addr_out = addr_reg;
  assign busy_out = busy_reg;
  assign done_out = done_reg;
  assign vector_out = vec_reg;

  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      busy_reg <= 1'b0;
      single_reg <= 1'b0;
      done_reg <= 1'b0;
      cnt_reg <= 2'h0;
      addr_reg <= {AW{1'b0}};
      vec_reg <= 32'h0;
    end else if (ce_in) begin
      done_reg <= 1'b0;
      if (start_in && !busy_reg) begin
        busy_reg <= 1'b1;
        single_reg <= single_in;
        cnt_reg <= 2'h0;
        addr_reg <= addr_in;
        vec_reg <= 32'h0;
      end else if (busy_reg && mem_ack_in) begin
        vec_reg[cnt_reg*8 +: 8] <= mem_data_in;
        cnt_reg <= cnt_reg + 2'h1;
        addr_reg <= addr_reg + {{(AW-1){1'b0}}, 1'b1};
        if (last) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire
